/* File: switch_frontend_defines.svh */
// Constants of the high side switch serial front end
`ifndef SWITCH_FRONTEND_DEFINES_SVH
`define SWITCH_FRONTEND_DEFINES_SVH
`define FRAME_LAST     4'hf
`define CNT_LAST_TX    4'he
`define WD_BIT         15
`define ADDR_HI        12
`define ADDR_LO        9
`define DATA_HI        8
`define GCR_ADDR       4'h0
`define RDSEL_ADDR     4'hf
`define GCR_SEL0       0
`define GCR_SEL1       1
`define GCR_TH         2
`define GCR_RESET      3'h0
`define RD_STATUS      3'h0
`define RD_FAULT0      3'h1
`define RD_FAULT1      3'h2
`define RD_DIAG0       3'h3
`define RD_DIAG1       3'h4
`define RD_GCR         3'h5
`define RD_EXT0        3'h6
`define RD_EXT1        3'h7
`define SRC_OFF        2'b00
`define SRC_CH0        2'b01
`define SRC_CH1        2'b10
`define SRC_TEMP       2'b11
`define PIN_RST        6
`define PIN_CS         5
`define PIN_DIR_HI     4
`define PIN_DIR_LO     3
`define PIN_LT_HI      2
`define PIN_LT_LO      1
`define PIN_PWMCLK     0
`define PIN_RESET      7'h27
`define CLK_MHZ        100
`define WD_TIMEOUT_US  1000
`define SLEEP_DELAY_US 200
`define CLK_FAIL_US    100
`define SETTLE_NS      2000
`define SETTLE_CYCLES  16'((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`endif

/* File: switch_frontend_pkg.sv */
// Types of the high side switch serial front end
`default_nettype none
package switch_frontend_pkg;
   typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE} mode_t;
   typedef struct packed {
      logic overcurrent_fault;
      logic overtemp_fault;
      logic short_to_supply;
      logic severe_short_fault;
      logic open_load_on_state;
      logic open_load_off_state;
   } chan_fault_t;
   typedef struct packed {
      logic overvoltage_fault;
      logic undervoltage_fault;
      logic clock_fail;
   } dev_fault_t;
   typedef struct packed {
      logic       enable;
      logic [1:0] source;
      logic       hold;
   } sense_route_t;
   typedef struct packed {
      logic       valid;
      logic [3:0] addr;
      logic [8:0] data;
   } reg_write_t;
   typedef struct packed {
      logic [3:0]  cnt;
      logic [14:0] shift;
   } rx_state_t;
   typedef struct packed {
      logic [15:0] word;
      logic        tgl;
   } link_state_t;
   typedef struct packed {
      logic [3:0] cnt;
      logic       so;
   } tx_state_t;
   typedef struct packed {
      logic [6:0]   s1;
      logic [6:0]   s2;
      logic [6:0]   s3;
      logic [6:0]   pf;
      logic [6:0]   pp;
      logic         tg1;
      logic         tg2;
      logic         tg3;
      logic [1:0]   frames;
      mode_t        mode;
      logic [15:0]  tx_word;
      logic [2:0]   rd_sel;
      logic [2:0]   global_config_reg;
      chan_fault_t  [1:0] chf;
      dev_fault_t   devf;
      logic         wd_last;
      logic         wd_armed;
      logic [31:0]  wd_cnt;
      logic [31:0]  sleep_cnt;
      logic [31:0]  clk_cnt;
      logic [1:0]   hs_prev;
      logic [15:0]  settle;
      logic         sync_low;
      sense_route_t sense;
      reg_write_t   wr;
   } sys_state_t;
endpackage : switch_frontend_pkg
`default_nettype wire

/* File: switch_control_frontend.sv */
// Digital control front end of a dual high side switch
`timescale 1ns/1ns
`default_nettype none
`include "switch_frontend_defines.svh"
// Behaviour
// RL1 - Two select bits route channel current or temperature to sense; both clear tri-states it.
// RL2 - Track-and-hold keeps presenting the current captured just before channel turn-off.
// RL3 - Sense output disabled while an over-current window of its channel is active.
// RL4 - No sensing in fail-safe, nor in normal mode without serial-port supply.
// RL5 - Sense-sync pulled low while sense output is accurate; valid until released.
// RL6 - Sense-sync released with a rising edge at every turn-off of the channel.
// RL7 - Direct input low turns channel off, high turns it on, under direct control.
// RL8 - In sleep, a rising edge on either direct input wakes the device.
// RL9 - Load-type input low picks bulb profile, high picks motor; open reads high.
// RL10 - Fault flag pulled low on any listed fault.
// RL11 - Each fault has its own bit; reading its register reports and clears it.
// RL12 - External PWM clock monitored, drives channel timing, its failure is a fault.
// RL13 - All serial register contents held at reset values while reset is low.
// RL14 - With reset low, sleep follows a delay after the last direct input falls.
// RL15 - Reset rising edge wakes and arms watchdog on first frame bit toggling; here the watchdog is armed at the reset rising edge itself.
// RL16 - Transfer only while select low; select rising latches word to its address.
// RL17 - Select falling loads one of eight readable registers; output driven while low.
// RL18 - Host changes select only with serial clock low, keeps clock low when idle.
// RL19 - Input sampled on falling clock edges; output updated on rising edges.
// RL20 - With select high, clock and input ignored, output high impedance.
// RL21 - Frames are 16 bits, MSB first; address in bits 12 to 9.
// RL22 - Output carries a readable register or the previous input word for chaining.
// RL23 - Watchdog counts system cycles, restarted by each toggle of the first bit.
module switch_control_frontend #(
   parameter int WD_TIMEOUT_CYCLES  = `WD_TIMEOUT_US * `CLK_MHZ,
   parameter int SLEEP_DELAY_CYCLES = `SLEEP_DELAY_US * `CLK_MHZ,
   parameter int CLK_FAIL_CYCLES    = `CLK_FAIL_US * `CLK_MHZ
) (
   input  wire logic                              clk_sys,
   input  wire logic                              reset_n,
   input  wire logic                              clk_en,
   input  wire logic                              serial_clk,
   input  wire logic                              chip_select_n,
   input  wire logic                              serial_in,
   output logic                                   serial_out,
   output logic                                   serial_out_oe,
   input  wire logic                              daisy_chain_mode,
   input  wire logic                              wake_reset_n,
   input  wire logic [1:0]                        direct_in,
   input  wire logic [1:0]                        load_type_sel,
   input  wire logic                              pwm_clk_in,
   input  wire logic [1:0]                        ext_clock_used,
   input  wire logic                              vdd_present,
   input  wire logic [1:0]                        hs_on,
   input  wire logic [1:0]                        oc_window_active,
   input  wire switch_frontend_pkg::chan_fault_t [1:0] chan_fault_in,
   input  wire switch_frontend_pkg::dev_fault_t   dev_fault_in,
   input  wire logic [15:0]                       ext_read_0,
   input  wire logic [15:0]                       ext_read_1,
   output logic [1:0]                             direct_on,
   output logic [1:0]                             overcurrent_profile,
   output logic                                   pwm_clk_edge,
   output logic [1:0]                             mode,
   output switch_frontend_pkg::sense_route_t      sense_route,
   output logic                                   sense_sync_oe,
   output logic                                   fault_flag_oe,
   output switch_frontend_pkg::reg_write_t        reg_write
);
   switch_frontend_pkg::rx_state_t   rx, next_rx;
   switch_frontend_pkg::link_state_t lk, next_lk;
   switch_frontend_pkg::tx_state_t   tx, next_tx;
   switch_frontend_pkg::sys_state_t  q, next_q;

   // Readable register mux, used only for the output word load
   function automatic logic [15:0] read_mux(
      input logic [2:0]                          sel,
      input switch_frontend_pkg::sys_state_t     s,
      input logic [15:0]                         e0,
      input logic [15:0]                         e1
   );
      logic [15:0] r;
      r = 16'h0000;
      case (sel)
         `RD_STATUS: r = {9'h000, s.mode, s.devf, |s.chf[1], |s.chf[0]};
         `RD_FAULT0: r = {12'h000, s.chf[0][5:2]};
         `RD_FAULT1: r = {12'h000, s.chf[1][5:2]};
         `RD_DIAG0:  r = {14'h0000, s.chf[0][1:0]};
         `RD_DIAG1:  r = {14'h0000, s.chf[1][1:0]};
         `RD_GCR:    r = {13'h0000, s.global_config_reg};
         `RD_EXT0:   r = e0;
         `RD_EXT1:   r = e1;
         default:    r = 16'h0000;
      endcase
      return r;
   endfunction : read_mux

   // Link side: input shifted on falling clock, counter cleared by select high
   always_comb begin
      next_rx = rx;
      next_lk = lk;
      next_rx.shift = {rx.shift[13:0], serial_in};                              // [RL19]
      next_rx.cnt = rx.cnt + 4'h1;
      if (rx.cnt == `FRAME_LAST) begin                                         // [RL21]
         next_lk.word = {rx.shift, serial_in};
         next_lk.tgl = ~lk.tgl;
      end
   end

   always_ff @(negedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n)
         rx <= '0;                                                              // [RL20]
      else
         rx <= next_rx;
   end

   always_ff @(negedge serial_clk or negedge reset_n) begin
      if (!reset_n)
         lk <= '0;
      else if (!chip_select_n)
         lk <= next_lk;
   end

   // Output updated on rising clock; tx_word changes only at cs_fall, after the select pin filter
   always_comb begin
      next_tx = tx;
      next_tx.cnt = (tx.cnt == `FRAME_LAST) ? tx.cnt : tx.cnt + 4'h1;
      next_tx.so = q.tx_word[`FRAME_LAST - tx.cnt];
   end

   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n)
         tx <= '0;
      else
         tx <= next_tx;                                                         // [RL19]
   end

   assign serial_out    = (tx.cnt == 4'h0) ? q.tx_word[`WD_BIT] : tx.so;
   assign serial_out_oe = ~chip_select_n;                                       // [RL17] [RL20]

   // System side
   logic        rst_pin;
   logic        rst_rise;
   logic        cs_rise;
   logic        cs_fall;
   logic [1:0]  dir_f;
   logic [1:0]  dir_rise;
   logic        frame_evt;
   logic        pwm_edge;
   logic [15:0] rd_word;
   logic [3:0]  waddr;
   logic [1:0]  turn_off;
   logic        src_on;
   logic        src_off_evt;
   logic        sense_ok;

   always_comb begin
      next_q = q;
      rst_pin   = q.pf[`PIN_RST];
      rst_rise  = q.pf[`PIN_RST] & ~q.pp[`PIN_RST];
      cs_rise   = q.pf[`PIN_CS] & ~q.pp[`PIN_CS];
      cs_fall   = ~q.pf[`PIN_CS] & q.pp[`PIN_CS];
      dir_f     = q.pf[`PIN_DIR_HI:`PIN_DIR_LO];
      dir_rise  = dir_f & ~q.pp[`PIN_DIR_HI:`PIN_DIR_LO];
      frame_evt = q.tg2 ^ q.tg3;
      pwm_edge  = q.pf[`PIN_PWMCLK] & ~q.pp[`PIN_PWMCLK];
      rd_word   = read_mux(q.rd_sel, q, ext_read_0, ext_read_1);
      waddr     = lk.word[`ADDR_HI:`ADDR_LO];
      turn_off  = q.hs_prev & ~hs_on;
      src_on    = (q.global_config_reg[1:0] == `SRC_CH0) ? hs_on[0] :
                  (q.global_config_reg[1:0] == `SRC_CH1) ? hs_on[1] : 1'b1;
      src_off_evt = (q.global_config_reg[1:0] == `SRC_CH0) ? turn_off[0] :
                    (q.global_config_reg[1:0] == `SRC_CH1) ? turn_off[1] : 1'b0;
      // Pin filter: a change counts once the second and third stage agree
      next_q.s1 = {wake_reset_n, chip_select_n, direct_in, load_type_sel, pwm_clk_in};
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      next_q.pf = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.pf);
      next_q.pp = q.pf;
      next_q.tg1 = lk.tgl;
      next_q.tg2 = q.tg1;
      next_q.tg3 = q.tg2;
      next_q.hs_prev = hs_on;
      next_q.wr.valid = 1'b0;
      // Frame counting and latching at select rising edge
      if (cs_fall)
         next_q.frames = 2'd0;
      else if (frame_evt && q.frames != 2'd2)
         next_q.frames = q.frames + 2'd1;
      if (cs_rise && q.frames == 2'd1 && rst_pin) begin                         // [RL16] [RL21]
         if (waddr == `GCR_ADDR)
            next_q.global_config_reg = lk.word[`GCR_TH:`GCR_SEL0];
         else if (waddr == `RDSEL_ADDR)
            next_q.rd_sel = lk.word[2:0];
         else begin
            next_q.wr.valid = 1'b1;
            next_q.wr.addr = waddr;
            next_q.wr.data = lk.word[`DATA_HI:0];
         end
         if (q.wd_armed && lk.word[`WD_BIT] != q.wd_last)                       // [RL15]
            next_q.wd_cnt = 32'd0;                                              // [RL23]
         next_q.wd_last = lk.word[`WD_BIT];
      end
      // Load of the output word, with clear-on-read of fault bits
      if (cs_fall) begin
         next_q.tx_word = daisy_chain_mode ? lk.word : rd_word;                 // [RL17] [RL22]
         case (q.rd_sel)
            `RD_STATUS: next_q.devf = '0;                                       // [RL11]
            `RD_FAULT0: next_q.chf[0][5:2] = 4'h0;
            `RD_FAULT1: next_q.chf[1][5:2] = 4'h0;
            `RD_DIAG0:  next_q.chf[0][1:0] = 2'h0;
            `RD_DIAG1:  next_q.chf[1][1:0] = 2'h0;
            default:    next_q.devf = q.devf;
         endcase
      end
      // External clock monitor
      if (pwm_edge || ext_clock_used == 2'b00)
         next_q.clk_cnt = 32'd0;
      else if (q.clk_cnt < 32'(CLK_FAIL_CYCLES))
         next_q.clk_cnt = q.clk_cnt + 32'd1;
      // Sticky faults: a new event wins over the clear above
      next_q.chf[0] = next_q.chf[0] | chan_fault_in[0];                         // [RL11]
      next_q.chf[1] = next_q.chf[1] | chan_fault_in[1];
      next_q.devf = next_q.devf | dev_fault_in;
      if (q.clk_cnt >= 32'(CLK_FAIL_CYCLES))
         next_q.devf.clock_fail = 1'b1;                                         // [RL12]
      // Operating mode
      if (q.wd_armed && q.wd_cnt < 32'(WD_TIMEOUT_CYCLES))
         next_q.wd_cnt = next_q.wd_cnt + 32'd1;
      if (!rst_pin) begin
         next_q.global_config_reg = `GCR_RESET;                                               // [RL13]
         next_q.rd_sel = `RD_STATUS;
         next_q.chf = '0;
         next_q.devf = '0;
         next_q.wd_armed = 1'b0;
         next_q.wd_cnt = 32'd0;
         if (dir_f != 2'b00 || dir_rise != 2'b00) begin
            next_q.sleep_cnt = 32'd0;
            next_q.mode = switch_frontend_pkg::MODE_NORMAL;                     // [RL8]
         end else if (q.sleep_cnt < 32'(SLEEP_DELAY_CYCLES))
            next_q.sleep_cnt = q.sleep_cnt + 32'd1;
         else
            next_q.mode = switch_frontend_pkg::MODE_SLEEP;                      // [RL14]
      end else if (rst_rise) begin
         next_q.mode = switch_frontend_pkg::MODE_NORMAL;                        // [RL15]
         next_q.wd_armed = 1'b1;
         next_q.wd_cnt = 32'd0;
      end else if (q.wd_armed && q.wd_cnt >= 32'(WD_TIMEOUT_CYCLES))
         next_q.mode = switch_frontend_pkg::MODE_FAILSAFE;                      // [RL15]
      // Sense routing and sync
      sense_ok = q.mode == switch_frontend_pkg::MODE_NORMAL && vdd_present;     // [RL4]
      if ((q.global_config_reg[1:0] == `SRC_CH0 && oc_window_active[0]) ||
          (q.global_config_reg[1:0] == `SRC_CH1 && oc_window_active[1]))
         sense_ok = 1'b0;                                                       // [RL3]
      next_q.sense.enable = sense_ok && q.global_config_reg[1:0] != `SRC_OFF;                 // [RL1]
      next_q.sense.source = q.global_config_reg[1:0];
      next_q.sense.hold = q.global_config_reg[`GCR_TH] && !src_on;                            // [RL2]
      if (!next_q.sense.enable || !src_on || src_off_evt) begin
         next_q.settle = 16'h0000;
         next_q.sync_low = 1'b0;                                                // [RL6]
      end else if (q.settle < `SETTLE_CYCLES)
         next_q.settle = q.settle + 16'h0001;
      else
         next_q.sync_low = 1'b1;                                                // [RL5]
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.s1 <= `PIN_RESET;
         q.s2 <= `PIN_RESET;
         q.s3 <= `PIN_RESET;
         q.pf <= `PIN_RESET;
         q.pp <= `PIN_RESET;
         q.mode <= switch_frontend_pkg::MODE_SLEEP;
      end else if (clk_en)
         q <= next_q;
   end

   assign direct_on           = q.pf[`PIN_DIR_HI:`PIN_DIR_LO];                  // [RL7]
   assign overcurrent_profile = q.pf[`PIN_LT_HI:`PIN_LT_LO];                    // [RL9]
   assign pwm_clk_edge        = pwm_edge;                                       // [RL12]
   assign mode                = q.mode;
   assign sense_route         = q.sense;
   assign sense_sync_oe       = q.sync_low;
   assign fault_flag_oe       = (|q.chf[0]) | (|q.chf[1]) | (|q.devf);         // [RL10]
   assign reg_write           = q.wr;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_sense_failsafe_off: assert property (                                      // [RL4]
      q.mode == switch_frontend_pkg::MODE_FAILSAFE && clk_en |=> !sense_route.enable)
      else $error("sense enabled in fail-safe");
   a_sense_oc_block: assert property (                                          // [RL3]
      clk_en && oc_window_active[0] && q.global_config_reg[1:0] == `SRC_CH0 |=> !sense_route.enable)
      else $error("sense enabled during over-current window");
   a_sense_off_sel: assert property (                                           // [RL1]
      clk_en && q.global_config_reg[1:0] == `SRC_OFF |=> !sense_route.enable)
      else $error("sense driven with both select bits clear");
   a_sync_turnoff: assert property (                                            // [RL6]
      clk_en && src_off_evt |=> !sense_sync_oe)
      else $error("sync not released at turn-off");
   a_fault_flag_set: assert property (                                          // [RL10]
      clk_en && rst_pin && (|chan_fault_in[0] || |chan_fault_in[1] || |dev_fault_in)
      |=> fault_flag_oe)
      else $error("fault flag not asserted on fault");
   a_wd_failsafe: assert property (                                             // [RL15]
      clk_en && rst_pin && !rst_rise && q.wd_armed && q.wd_cnt >= 32'(WD_TIMEOUT_CYCLES)
      |=> q.mode == switch_frontend_pkg::MODE_FAILSAFE)
      else $error("watchdog timeout without fail-safe");
   a_reset_holds_cfg: assert property (                                         // [RL13]
      clk_en && !rst_pin |=> q.global_config_reg == `GCR_RESET && q.rd_sel == `RD_STATUS)
      else $error("registers not held at reset");
   a_sleep_wake: assert property (                                              // [RL8]
      clk_en && q.mode == switch_frontend_pkg::MODE_SLEEP && dir_rise != 2'b00
      |=> q.mode == switch_frontend_pkg::MODE_NORMAL)
      else $error("direct input edge did not wake");
   a_so_tristate: assert property (                                             // [RL20]
      chip_select_n |-> !serial_out_oe && rx.cnt == 4'h0 && tx.cnt == 4'h0)
      else $error("serial output driven with select high");
   a_gcr_latch: assert property (                                               // [RL16]
      clk_en && cs_rise && q.frames == 2'd1 && rst_pin && waddr == `GCR_ADDR
      |=> q.global_config_reg == $past(lk.word[`GCR_TH:`GCR_SEL0]))
      else $error("configuration word not latched");

   // Further guards on sense, faults, watchdog, sleep and serial loading

   a_sense_oc_ch1: assert property (                                            // [RL3]
      clk_en && oc_window_active[1] && q.global_config_reg[1:0] == `SRC_CH1 |=> !sense_route.enable)
      else $error("sense enabled during channel 1 over-current window");

   a_sense_no_vdd: assert property (                                            // [RL4]
      clk_en && !vdd_present |=> !sense_route.enable)
      else $error("sense enabled without serial-port supply");

   a_hold_track: assert property (                                              // [RL2]
      clk_en && q.global_config_reg[`GCR_TH] && q.global_config_reg[1:0] == `SRC_CH0 && !hs_on[0] |=> sense_route.hold)
      else $error("track-and-hold not kept while channel off");

   a_sync_settle: assert property (                                             // [RL5]
      clk_en && !sense_sync_oe && q.settle < `SETTLE_CYCLES |=> !sense_sync_oe)
      else $error("sync pulled low before sense settled");

   a_read_clears: assert property (                                             // [RL11]
      clk_en && rst_pin && cs_fall && q.rd_sel == `RD_FAULT0 && chan_fault_in[0] == '0
      |=> q.chf[0][5:2] == 4'h0)
      else $error("fault bits not cleared by read");

   a_clock_fail_set: assert property (                                          // [RL12]
      clk_en && rst_pin && q.clk_cnt >= 32'(CLK_FAIL_CYCLES) |=> q.devf.clock_fail)
      else $error("missing external clock not reported");

   a_wake_arm: assert property (                                                // [RL15]
      clk_en && rst_rise |=> q.mode == switch_frontend_pkg::MODE_NORMAL && q.wd_armed)
      else $error("wake edge did not arm watchdog");

   a_wd_restart: assert property (                                              // [RL23]
      clk_en && rst_pin && cs_rise && q.frames == 2'd1 && q.wd_armed &&
      lk.word[`WD_BIT] != q.wd_last |=> q.wd_cnt <= 32'd1)
      else $error("watchdog not restarted by toggled bit");

   a_sleep_entry: assert property (                                             // [RL14]
      clk_en && !rst_pin && dir_f == 2'b00 && q.sleep_cnt >= 32'(SLEEP_DELAY_CYCLES)
      |=> q.mode == switch_frontend_pkg::MODE_SLEEP)
      else $error("sleep not entered after delay");

   a_write_pulse: assert property (                                             // [RL16]
      clk_en && reg_write.valid |=> !reg_write.valid)
      else $error("register write strobe longer than one cycle");

   a_tx_load: assert property (                                                 // [RL17]
      clk_en && cs_fall && !daisy_chain_mode |=> q.tx_word == $past(rd_word))
      else $error("readable register not loaded at select fall");

   a_daisy_load: assert property (                                              // [RL22]
      clk_en && cs_fall && daisy_chain_mode |=> q.tx_word == $past(lk.word))
      else $error("received word not loaded for chaining");
endmodule : switch_control_frontend
`default_nettype wire

/* File: spi_host_model.sv */
// Serial port master that stands in for the host controller
`timescale 1ns/1ns
`default_nettype none
module spi_host_model #(
   parameter int HALF_NS = 24
) (
   output logic      serial_clk,
   output logic      chip_select_n,
   output logic      serial_in,
   input  wire logic serial_out
);
   initial begin
      serial_clk    = 1'b0;
      chip_select_n = 1'b1;
      serial_in     = 1'b0;
   end
   // One 16-bit frame; the clock stands low outside frames, released input is pulled down
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      chip_select_n = 1'b0;
      #500;
      for (int k = 15; k >= 0; k--) begin
         serial_in = tx[k];
         #(HALF_NS / 2);
         serial_clk = 1'b1;
         #HALF_NS;
         serial_clk = 1'b0;
         rx[k] = serial_out;
         #(HALF_NS / 2);
      end
      #60;
      chip_select_n = 1'b1;
      serial_in     = 1'b0;
      #1000;
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: switch_control_serial_frontend_tb_top.sv */
// Self-checking bench for the switch serial front end
`timescale 1ns/1ns
`default_nettype none
module switch_control_serial_frontend_tb_top;
   localparam int WD_CYC = 500;
   localparam int SLEEP_CYC = 100;
   localparam int CLKF_CYC = 200;
   logic clk_sys, reset_n, clk_en, serial_clk, chip_select_n, serial_in, serial_out, so_oe;
   logic daisy, wake_n, vdd, pwm, sync_oe, flag_oe, pwm_edge, tgl;
   logic [1:0] dir, lt, ext_clk, hs, ocw, dir_on, prof, mode;
   logic [15:0] rx, last, prev, ext0, ext1;
   switch_frontend_pkg::chan_fault_t [1:0] chf;
   switch_frontend_pkg::dev_fault_t devf;
   switch_frontend_pkg::sense_route_t route;
   switch_frontend_pkg::reg_write_t wr, wr_seen;
   int n_errors, num_checks;

   switch_control_frontend #(.WD_TIMEOUT_CYCLES(WD_CYC), .SLEEP_DELAY_CYCLES(SLEEP_CYC),
      .CLK_FAIL_CYCLES(CLKF_CYC)) i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .serial_clk(serial_clk),
      .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe(so_oe), .daisy_chain_mode(daisy), .wake_reset_n(wake_n),
      .direct_in(dir), .load_type_sel(lt), .pwm_clk_in(pwm), .ext_clock_used(ext_clk),
      .vdd_present(vdd), .hs_on(hs), .oc_window_active(ocw), .chan_fault_in(chf),
      .dev_fault_in(devf), .ext_read_0(ext0), .ext_read_1(ext1), .direct_on(dir_on),
      .overcurrent_profile(prof), .pwm_clk_edge(pwm_edge), .mode(mode), .sense_route(route),
      .sense_sync_oe(sync_oe), .fault_flag_oe(flag_oe), .reg_write(wr));
   spi_host_model i_host (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
      .serial_in(serial_in), .serial_out(serial_out));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   // Watchdog bit flips every frame so the watchdog stays fed
   task automatic frame(input logic [3:0] addr, input logic [8:0] data);
      tgl  = ~tgl;
      last = {tgl, 2'b00, addr, data};
      i_host.xfer(last, rx);
      @(negedge clk_sys);
   endtask : frame
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #300000;
      n_errors++;
      close_out();
   end
   always @(negedge clk_sys) begin
      if (wr.valid === 1'b1) wr_seen <= wr;
   end

   initial begin
      reset_n = 1'b0; clk_en = 1'b1; daisy = 1'b0; wake_n = 1'b0; dir = 2'b00; lt = 2'b10;
      pwm = 1'b0; ext_clk = 2'b00; vdd = 1'b1; hs = 2'b00; ocw = 2'b00; chf = '0; devf = '0;
      ext0 = 16'h5a3c; ext1 = 16'hc3a5; tgl = 1'b0; wr_seen = '0;
      cyc(16);
      reset_n = 1'b1;
      cyc(10);
      check(prof, 2'b10);
      check(so_oe, 1'b0);
      dir = 2'b01;
      cyc(10);
      check(mode, 2'h1);
      check(dir_on, 2'b01);
      dir = 2'b00;
      cyc(SLEEP_CYC / 2);
      check(mode, 2'h1);
      cyc(SLEEP_CYC);
      check(mode, 2'h0);
      check(dir_on, 2'b00);
      $display("test direct and sleep done");
      wake_n = 1'b1;
      cyc(110);
      check(mode, 2'h1);
      frame(4'h3, 9'h1a5);
      check(wr_seen, {1'b1, 4'h3, 9'h1a5});
      frame(4'hf, 9'h006);
      frame(4'h3, 9'h000);
      check(rx, ext0);
      frame(4'hf, 9'h007);
      frame(4'h3, 9'h000);
      check(rx, ext1);
      daisy = 1'b1;
      frame(4'h5, 9'h0c3);
      prev = last;
      frame(4'h6, 9'h13c);
      check(rx, prev);
      daisy = 1'b0;
      $display("test serial frames done");
      frame(4'h0, 9'h005);
      hs = 2'b01;
      cyc(5);
      check(route, {1'b1, 2'b01, 1'b0});
      cyc(205);
      check(sync_oe, 1'b1);
      hs = 2'b00;
      cyc(3);
      check(sync_oe, 1'b0);
      check(route.hold, 1'b1);
      ocw = 2'b01;
      cyc(3);
      check(route.enable, 1'b0);
      ocw = 2'b00;
      vdd = 1'b0;
      cyc(3);
      check(route.enable, 1'b0);
      vdd = 1'b1;
      frame(4'h0, 9'h000);
      check(route.enable, 1'b0);
      $display("test sense done");
      chf[0].overcurrent_fault = 1'b1;
      cyc(1);
      chf[0].overcurrent_fault = 1'b0;
      cyc(3);
      check(flag_oe, 1'b1);
      frame(4'hf, 9'h001);
      frame(4'h3, 9'h000);
      check(rx[3], 1'b1);
      check(flag_oe, 1'b0);
      $display("test faults done");
      frame(4'h0, 9'h006);
      cyc(WD_CYC + 100);
      check(mode, 2'h2);
      pwm = 1'b1;
      cyc(4);
      check(pwm_edge, 1'b1);
      cyc(1);
      check(pwm_edge, 1'b0);
      pwm = 1'b0;
      ext_clk = 2'b01;
      cyc(CLKF_CYC + 50);
      check(flag_oe, 1'b1);
      wake_n = 1'b0;
      tgl = 1'b0;
      cyc(20);
      wake_n = 1'b1;
      cyc(110);
      frame(4'hf, 9'h005);
      frame(4'h3, 9'h000);
      check(rx[2:0], 3'h0);
      $display("test watchdog and reset done");
      close_out();
   end
endmodule : switch_control_serial_frontend_tb_top
`default_nettype wire
